// [hdl/pipe_input_format_map.svh]
// register offsets, field positions, reset values and widths of the input-format configuration block
// assumes a 32-bit APB slave with an 8-bit byte address, one aligned word per register
`ifndef PIPE_INPUT_FORMAT_MAP_SVH
`define PIPE_INPUT_FORMAT_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_DECOMPRESS_CONFIG 8'h00
`define OFS_INPUT_CONFIG_TWO 8'h04
`define OFS_RESIZE_START_POSITION 8'h08
`define OFS_OUTPUT_CLIP_LIMIT 8'h0C
`define OFS_GAIN_FACTOR 8'h10
`define OFS_BLOCK_CONTROL 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_DECOMPRESS_ON 0
`define BIT_PREDICTOR_SEL 1
`define BIT_DECOMPRESS_WIDTH 2
`define BIT_IRQ_SOURCE_SEL 0
`define BIT_HSYNC_POLARITY 1
`define BIT_VSYNC_POLARITY 2
`define BIT_INPUT_TYPE_SEL 3
`define BIT_EXT_WRITE_QUAL_SEL 4
`define BIT_FRAME_SUBTRACT_DIR 5
`define BIT_BYTE_LUMA_CHROMA_MODE 6
`define BIT_CHROMA_PHASE_SEL 7
`define BIT_SYNC_REALIGN 13
`define BIT_BLOCK_ENABLE 0
`define BIT_SECOND_SOURCE_SELECT 1
`define BIT_IRQ_FRAME_START 0
`define BIT_IRQ_CLIP_HIT 1

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define RESIZE_POS_W 13
`define CLIP_W 12
`define GAIN_W 10
`define GAIN_SHIFT 9
`define IRQ_W 2
`define RESET_CLIP_LIMIT 12'hFFF
`define RESET_GAIN 10'h200
`define DECOMPRESS_CONFIG_CODE_W 8
`define DECOMPRESS_CONFIG_MAX_10BIT 12'h3FF
`define DECOMPRESS_CONFIG_MAX_12BIT 12'hFFF

`endif

// [hdl/pipe_input_format_pkg.sv]
// types shared by the input-format configuration block, its pixel source and its bench
// assumes the map header supplies every numeric constant
package pipe_input_format_pkg;

  // ----------------------------------------
  // stream carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic hsync;
    logic vsync;
    logic wen;
  } pix_in_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic hsync;
    logic vsync;
  } pix_out_type;

  // path through the block, chosen by the input type and byte mode bits
  typedef enum logic [1:0] {
    RAW_PATH,
    WORD_PATH,
    PAIR_PATH
  } path_mode_type;

endpackage : pipe_input_format_pkg

// [hdl/decompress_config_decoder.sv]
// expands 8-bit difference codes to 10- or 12-bit raw samples, or passes samples through
// assumes codes arrive in the low byte and one line starts with line_start
`timescale 1ns/1ps
`include "pipe_input_format_map.svh"

module decompress_config_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic decompress_on,
  input wire logic predictor_sel,
  input wire logic width_sel,
  input wire logic line_start,
  input wire logic valid,
  input wire logic [11:0] sample_in,
  output logic [11:0] sample_out
);

  logic [11:0] hist_one;
  logic [11:0] hist_two;
  logic [1:0] lead;
  logic [1:0] lead_now;
  logic [11:0] estimate;
  logic [11:0] top;
  logic signed [13:0] delta;
  logic signed [13:0] sum;
  logic [7:0] code;

  // ----------------------------------------
  // reconstruction
  // ----------------------------------------
  // the first two samples of a line have no same-colour neighbour, so they are sent scaled up
  always_comb begin
    code = sample_in[7:0];
    lead_now = line_start ? 2'h0 : lead;
    estimate = predictor_sel ? 12'((13'(hist_one) + 13'(hist_two)) >> 1) : hist_two;
    top = width_sel ? `DECOMPRESS_CONFIG_MAX_12BIT : `DECOMPRESS_CONFIG_MAX_10BIT;
    delta = {{6{code[7]}}, code};
    if (width_sel) begin
      delta = delta <<< 2;
    end
    sum = $signed({2'h0, estimate}) + delta;
    if (!decompress_on) begin
      sample_out = sample_in;
    end else if (lead_now != 2'h2) begin
      sample_out = width_sel ? {code, 4'h0} : {2'h0, code, 2'h0};
    end else if (sum < 14'sh0) begin
      sample_out = 12'h000;
    end else if (sum > $signed({2'h0, top})) begin
      sample_out = top;
    end else begin
      sample_out = sum[11:0];
    end
  end

  // ----------------------------------------
  // history of the last two samples
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_one <= 12'h000;
      hist_two <= 12'h000;
      lead <= 2'h0;
    end else if (valid) begin
      hist_one <= sample_out;
      hist_two <= hist_one;
      lead <= (lead_now == 2'h2) ? 2'h2 : 2'(lead_now + 2'h1);
    end else if (line_start) begin
      lead <= 2'h0;
    end
  end

endmodule : decompress_config_decoder

// [hdl/gain_clip.sv]
// scales a raw sample by gain/512 and limits it to the programmed ceiling
// assumes its result is used only for raw data; luma/chroma words bypass it at the output flop downstream
`timescale 1ns/1ps
`include "pipe_input_format_map.svh"

module gain_clip (
  input wire logic [11:0] sample_in,
  input wire logic [9:0] gain,
  input wire logic [11:0] limit,
  output logic [11:0] sample_out,
  output logic clip_hit
);

  logic [21:0] product;
  logic [12:0] scaled;

  // ----------------------------------------
  // multiply, then take the smaller of result and limit
  // ----------------------------------------
  always_comb begin
    product = 22'(sample_in) * 22'(gain);
    scaled = product[21:`GAIN_SHIFT];
    clip_hit = scaled > {1'b0, limit};
    sample_out = clip_hit ? limit : scaled[11:0];
  end

endmodule : gain_clip

// [hdl/pipe_input_format_config.sv]
// input-format stage of the image pipe: APB registers, sync handling, byte pairing,
// decompression, gain and clipping, and the frame-start and clip-hit interrupts
// assumes pixel and sync inputs are synchronous to pclk and an APB master with 32-bit data
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "pipe_input_format_map.svh"

module pipe_input_format_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pipe_input_format_pkg::pix_in_type pix_in,
  input wire logic pp_vsync,
  input wire logic sif_vsync,
  output pipe_input_format_pkg::pix_out_type pix_out,
  output logic frame_subtract_direction,
  output logic irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic decompress_on;
  logic predictor_sel;
  logic decompress_width_sel;
  logic [7:0] input_config_two;
  logic [12:0] resize_start_pos;
  logic [11:0] output_clip_limit;
  logic [9:0] gain_factor;
  logic block_enable;
  logic second_source_select;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [31:0] rd_word;
  logic addr_hit;
  logic wr_en;
  logic sync_realign;
  logic input_type_eff;
  logic use_wen;
  pipe_input_format_pkg::path_mode_type mode;
  logic hs_act;
  logic vs_act;
  logic hs_prev;
  logic irq_vs_prev;
  logic irq_vs_act;
  logic line_start;
  logic frame_start;
  logic [12:0] pos;
  logic in_window;
  logic qual;
  logic byte_phase;
  logic [7:0] byte_hold;
  logic s1_valid;
  logic [15:0] s1_data;
  logic s1_hs;
  logic s1_vs;
  logic s1_line_start;
  pipe_input_format_pkg::path_mode_type s1_mode;
  logic [11:0] dec_sample;
  logic [11:0] clip_sample;
  logic clip_hit;
  logic clip_event;
  logic out_raw;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // read data is taken in the setup cycle so that prdata leaves a flop; one access cycle, no waits
  always_comb begin
    addr_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `OFS_DECOMPRESS_CONFIG: rd_word = {29'h0, decompress_width_sel, predictor_sel, decompress_on};
      `OFS_INPUT_CONFIG_TWO: rd_word = {24'h0, input_config_two};
      `OFS_RESIZE_START_POSITION: rd_word = {19'h0, resize_start_pos}; // realign bit reads as zero
      `OFS_OUTPUT_CLIP_LIMIT: rd_word = {20'h0, output_clip_limit};
      `OFS_GAIN_FACTOR: rd_word = {22'h0, gain_factor};
      `OFS_BLOCK_CONTROL: rd_word = {30'h0, second_source_select, block_enable};
      `OFS_IRQ_STATUS: rd_word = {30'h0, irq_status};
      `OFS_IRQ_MASK: rd_word = {30'h0, irq_mask};
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~addr_hit;
      end
    end
  end

  assign wr_en = psel & penable & pready & pwrite;
  assign sync_realign = wr_en && paddr == `OFS_RESIZE_START_POSITION && pwdata[`BIT_SYNC_REALIGN];

  // configuration registers; only defined bits are stored, reserved bits are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decompress_on <= 1'b0;
      predictor_sel <= 1'b0;
      decompress_width_sel <= 1'b0;
      input_config_two <= 8'h00;
      resize_start_pos <= 13'h0000;
      output_clip_limit <= `RESET_CLIP_LIMIT;
      gain_factor <= `RESET_GAIN;
      block_enable <= 1'b0;
      second_source_select <= 1'b0;
      irq_mask <= 2'h0;
    end else if (wr_en) begin
      unique case (paddr)
        `OFS_DECOMPRESS_CONFIG: begin
          decompress_on <= pwdata[`BIT_DECOMPRESS_ON];
          predictor_sel <= pwdata[`BIT_PREDICTOR_SEL];
          decompress_width_sel <= pwdata[`BIT_DECOMPRESS_WIDTH];
        end
        `OFS_INPUT_CONFIG_TWO: input_config_two <= pwdata[7:0];
        `OFS_RESIZE_START_POSITION: resize_start_pos <= pwdata[`RESIZE_POS_W-1:0];
        `OFS_OUTPUT_CLIP_LIMIT: output_clip_limit <= pwdata[`CLIP_W-1:0];
        `OFS_GAIN_FACTOR: gain_factor <= pwdata[`GAIN_W-1:0];
        `OFS_BLOCK_CONTROL: begin
          block_enable <= pwdata[`BIT_BLOCK_ENABLE];
          second_source_select <= pwdata[`BIT_SECOND_SOURCE_SELECT];
        end
        `OFS_IRQ_MASK: irq_mask <= pwdata[`IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_subtract_direction <= 1'b0;
    end else begin
      frame_subtract_direction <= input_config_two[`BIT_FRAME_SUBTRACT_DIR];
    end
  end

  // ----------------------------------------
  // mode and sync decoding
  // ----------------------------------------
  // input type is ignored unless the first source is selected
  assign input_type_eff = input_config_two[`BIT_INPUT_TYPE_SEL] & ~second_source_select;
  assign use_wen = input_config_two[`BIT_EXT_WRITE_QUAL_SEL] & block_enable;
  assign mode = !input_type_eff ? pipe_input_format_pkg::RAW_PATH :
                input_config_two[`BIT_BYTE_LUMA_CHROMA_MODE] ? pipe_input_format_pkg::PAIR_PATH :
                pipe_input_format_pkg::WORD_PATH;
  assign hs_act = pix_in.hsync ^ input_config_two[`BIT_HSYNC_POLARITY];
  assign vs_act = pix_in.vsync ^ input_config_two[`BIT_VSYNC_POLARITY];
  assign irq_vs_act = (input_config_two[`BIT_IRQ_SOURCE_SEL] ? sif_vsync : pp_vsync)
                      ^ input_config_two[`BIT_VSYNC_POLARITY];
  assign line_start = hs_act & ~hs_prev;
  assign frame_start = irq_vs_act & ~irq_vs_prev;
  assign in_window = pos >= resize_start_pos;
  assign qual = pix_in.valid & in_window & (~use_wen | pix_in.wen);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_prev <= 1'b0;
      irq_vs_prev <= 1'b0;
    end else begin
      hs_prev <= hs_act;
      irq_vs_prev <= irq_vs_act;
    end
  end

  // pixel position from horizontal sync; realign forces the counter to the start point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 13'h0000;
    end else if (sync_realign) begin
      pos <= resize_start_pos;
    end else if (line_start) begin
      pos <= 13'h0000;
    end else if (pix_in.valid && pos != 13'h1FFF) begin
      pos <= pos + 13'h0001; // saturates so a long line cannot wrap back before the start
    end
  end

  // ----------------------------------------
  // stage one: byte pairing and capture
  // ----------------------------------------
  // byte mode waits for two bytes; the phase bit says which of the pair carries chroma
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_phase <= 1'b0;
      byte_hold <= 8'h00;
      s1_valid <= 1'b0;
      s1_data <= 16'h0000;
      s1_hs <= 1'b0;
      s1_vs <= 1'b0;
      s1_line_start <= 1'b0;
      s1_mode <= pipe_input_format_pkg::RAW_PATH;
    end else begin
      s1_hs <= hs_act;
      s1_vs <= vs_act;
      s1_line_start <= line_start;
      s1_mode <= mode;
      s1_valid <= 1'b0;
      if (line_start) begin
        byte_phase <= 1'b0;
      end
      if (qual) begin
        if (mode == pipe_input_format_pkg::PAIR_PATH) begin
          byte_phase <= line_start ? 1'b1 : ~byte_phase;
          byte_hold <= pix_in.data[7:0];
          if (byte_phase && !line_start) begin
            s1_valid <= 1'b1;
            s1_data <= input_config_two[`BIT_CHROMA_PHASE_SEL] ? {byte_hold, pix_in.data[7:0]} :
                       {pix_in.data[7:0], byte_hold};
          end
        end else begin
          s1_valid <= 1'b1;
          s1_data <= pix_in.data;
        end
      end
    end
  end

  // ----------------------------------------
  // raw datapath
  // ----------------------------------------
  decompress_config_decoder u_decompress_config_decoder (
    .pclk(pclk),
    .presetn(presetn),
    .decompress_on(decompress_on),
    .predictor_sel(predictor_sel),
    .width_sel(decompress_width_sel),
    .line_start(s1_line_start),
    .valid(s1_valid && s1_mode == pipe_input_format_pkg::RAW_PATH),
    .sample_in(s1_data[11:0]),
    .sample_out(dec_sample)
  );

  gain_clip u_gain_clip (
    .sample_in(dec_sample),
    .gain(gain_factor),
    .limit(output_clip_limit),
    .sample_out(clip_sample),
    .clip_hit(clip_hit)
  );

  assign clip_event = s1_valid & (s1_mode == pipe_input_format_pkg::RAW_PATH) & clip_hit;

  // output flop; luma/chroma words skip gain and clipping entirely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_out <= '0;
      out_raw <= 1'b0;
    end else begin
      pix_out.valid <= s1_valid;
      pix_out.hsync <= s1_hs;
      pix_out.vsync <= s1_vs;
      out_raw <= s1_mode == pipe_input_format_pkg::RAW_PATH;
      if (s1_valid) begin
        pix_out.data <= (s1_mode == pipe_input_format_pkg::RAW_PATH) ? {4'h0, clip_sample} : s1_data;
      end
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // a new event in the cycle of a write-one clear keeps the bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~((wr_en && paddr == `OFS_IRQ_STATUS) ? pwdata[1:0] : 2'h0))
                    | {clip_event, frame_start};
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_level_a: assert property (irq == |($past(irq_status) & $past(irq_mask)))
    else $error("interrupt level does not follow masked status");
  frame_irq_a: assert property (frame_start |=> irq_status[`BIT_IRQ_FRAME_START])
    else $error("frame start did not set status");
  clip_bound_a: assert property ((pix_out.valid && out_raw)
      |-> pix_out.data <= {4'h0, $past(output_clip_limit)})
    else $error("raw output above clip limit");
  decomp_bypass_a: assert property ((s1_valid && !decompress_on) |-> dec_sample == s1_data[11:0])
    else $error("samples altered with decompression off");
  wen_gate_a: assert property ((pix_in.valid && use_wen && !pix_in.wen) |=> !s1_valid)
    else $error("pixel passed without external write enable");
  start_window_a: assert property ((pix_in.valid && !in_window) |=> !s1_valid)
    else $error("pixel passed before resize start");
  realign_pos_a: assert property (sync_realign |=> pos == $past(resize_start_pos))
    else $error("realign did not reload position");
  pair_first_a: assert property ((qual && mode == pipe_input_format_pkg::PAIR_PATH && !byte_phase)
      |=> !s1_valid)
    else $error("byte mode emitted a word on the first byte");
  chroma_even_a: assert property ((qual && mode == pipe_input_format_pkg::PAIR_PATH && byte_phase && !line_start
      && !input_config_two[`BIT_CHROMA_PHASE_SEL]) |=> s1_data == {$past(pix_in.data[7:0]), $past(byte_hold)})
    else $error("chroma phase zero packed wrongly");
  ycc_nogain_a: assert property ((s1_valid && s1_mode != pipe_input_format_pkg::RAW_PATH)
      |=> pix_out.data == $past(s1_data))
    else $error("gain applied to luma/chroma data");
  raw_latency_a: assert property ((qual && mode == pipe_input_format_pkg::RAW_PATH) |-> ##2 pix_out.valid)
    else $error("raw pixel not out after two cycles");

  pair_word_c: cover property (s1_valid && s1_mode == pipe_input_format_pkg::PAIR_PATH);
  clip_hit_c: cover property (clip_event);
  decompress_c: cover property (s1_valid && decompress_on && decompress_width_sel && predictor_sel);
  irq_raise_c: cover property ($rose(irq));

endmodule : pipe_input_format_config

// [verification/pixel_source.sv]
// stand-in for the sensor interface and parallel port that feed the block
// assumes every task is called just after a rising pclk edge
`timescale 1ns/1ps

module pixel_source (
  input wire logic pclk,
  output pipe_input_format_pkg::pix_in_type pix_in,
  output logic pp_vsync,
  output logic sif_vsync
);
  // idle: no valid word, syncs at their inactive level
  initial begin
    pix_in = '0;
    pp_vsync = 1'b0;
    sif_vsync = 1'b0;
  end

  // one-cycle hsync pulse unless with_sync is low, then one word a cycle; slow puts an idle cycle between words
  task automatic send_line(input logic [15:0] w[$], input logic [15:0] wen_map, input logic slow,
                           input logic with_sync = 1'b1);
    if (with_sync) begin
      pix_in.hsync <= ~pix_in.hsync;
      @(posedge pclk);
      pix_in.hsync <= ~pix_in.hsync;
    end
    foreach (w[i]) begin
      pix_in.valid <= 1'b1;
      pix_in.data <= w[i];
      pix_in.wen <= wen_map[i];
      @(posedge pclk);
      if (slow) begin
        pix_in.valid <= 1'b0;
        pix_in.data <= ~w[i]; // idle bus never repeats the last word
        @(posedge pclk);
      end
    end
    pix_in.valid <= 1'b0;
    pix_in.data <= ~pix_in.data;
  endtask : send_line

  // two-cycle frame start on one of the two vertical sync sources
  task automatic vpulse(input logic from_sensor);
    if (from_sensor) sif_vsync <= 1'b1;
    else pp_vsync <= 1'b1;
    repeat (2) @(posedge pclk);
    sif_vsync <= 1'b0;
    pp_vsync <= 1'b0;
  endtask : vpulse
endmodule : pixel_source

// [verification/pipe_input_format_config_tb_top.sv]
// self-checking bench: APB registers, raw, decompressed and luma/chroma paths, syncs, interrupt
// assumes the pixel_source partner and the one-access-cycle APB answer of the design
`timescale 1ns/1ps
`include "pipe_input_format_map.svh"

module pipe_input_format_config_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fsd, er, pp_vsync, sif_vsync;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pipe_input_format_pkg::pix_in_type pix_in;
  pipe_input_format_pkg::pix_out_type pix_out;
  logic [15:0] expq[$];
  logic [15:0] ln[$];
  int errors = 0;
  int n_compared = 0;
  int seed = 32'h813d;

  pipe_input_format_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_in(pix_in), .pp_vsync(pp_vsync), .sif_vsync(sif_vsync), .pix_out(pix_out),
    .frame_subtract_direction(fsd), .irq(irq));
  pixel_source src_u (.pclk(pclk), .pix_in(pix_in), .pp_vsync(pp_vsync), .sif_vsync(sif_vsync));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic push(input int v);
    expq.push_back(v[15:0]);
  endtask : push

  // one transfer; the idle edge at the end keeps back-to-back calls from colliding
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // output watcher: every valid word is matched with the oldest expected one
  always @(posedge pclk) begin
    if (presetn === 1'b1 && pix_out.valid === 1'b1) begin
      if (expq.size() == 0) check(32'h1, 32'h0);
      else check({16'h0, pix_out.data}, {16'h0, expq.pop_front()});
    end
  end

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int e, g, lim, k, mx, c0, c1, c2;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(`OFS_OUTPUT_CLIP_LIMIT, 32'hFFF);
    rchk(`OFS_GAIN_FACTOR, 32'h200);
    rchk(`OFS_DECOMPRESS_CONFIG, 32'h0);
    rchk(`OFS_INPUT_CONFIG_TWO, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1); // unmapped place answers with an error
    for (int i = 0; i < 4; i++) begin
      e = $random(seed) & 32'hF7;
      wr(`OFS_INPUT_CONFIG_TWO, e);
      rchk(`OFS_INPUT_CONFIG_TWO, e);
      check({31'h0, fsd}, {31'h0, e[5]});
      e = $random(seed) & 32'h3FFF;
      wr(`OFS_RESIZE_START_POSITION, e);
      rchk(`OFS_RESIZE_START_POSITION, e & 32'h1FFF);
    end
    wr(`OFS_RESIZE_START_POSITION, 32'h0);
    wr(`OFS_BLOCK_CONTROL, 32'h1);
    wr(`OFS_INPUT_CONFIG_TWO, 32'h0);
    // raw path with random gain and ceiling; wen is low but unused
    for (int i = 0; i < 6; i++) begin
      g = $random(seed) & 32'h3FF;
      lim = $random(seed) & 32'hFFF;
      wr(`OFS_GAIN_FACTOR, g);
      wr(`OFS_OUTPUT_CLIP_LIMIT, lim);
      ln = {};
      repeat (4) begin
        e = $random(seed) & 32'hFFF;
        ln.push_back(e[15:0]);
        e = (e * g) >> 9;
        push(e > lim ? lim : e);
      end
      src_u.send_line(ln, 16'h0, i[0]);
      repeat (3) @(posedge pclk);
    end
    // decompression: all width and predictor settings
    wr(`OFS_GAIN_FACTOR, 32'h200);
    wr(`OFS_OUTPUT_CLIP_LIMIT, 32'hFFF);
    for (int i = 0; i < 4; i++) begin
      k = i[1] ? 4 : 2;
      mx = i[1] ? 32'hFFF : 32'h3FF;
      c0 = $random(seed) & 32'hFF;
      c1 = $random(seed) & 32'hFF;
      c2 = $random(seed) & 32'h0F;
      wr(`OFS_DECOMPRESS_CONFIG, {29'h0, i[1], i[0], 1'b1});
      e = (i[0] ? ((c0 << k) + (c1 << k)) >> 1 : c0 << k) + c2 * (i[1] ? 4 : 1);
      push(c0 << k);
      push(c1 << k);
      push(e > mx ? mx : e);
      ln = {c0[15:0], c1[15:0], c2[15:0]};
      src_u.send_line(ln, 16'h0, 1'b0);
      repeat (3) @(posedge pclk);
    end
    wr(`OFS_DECOMPRESS_CONFIG, 32'h0);
    // luma/chroma: 16-bit words, then byte pairs in both chroma phases; gain and ceiling must not touch them
    wr(`OFS_GAIN_FACTOR, 32'h100);
    wr(`OFS_OUTPUT_CLIP_LIMIT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_INPUT_CONFIG_TWO, i == 0 ? 32'h08 : (i == 1 ? 32'h48 : 32'hC8));
      ln = {};
      repeat (4) begin
        c0 = $random(seed) & 32'hFFFF;
        c1 = $random(seed) & 32'hFF;
        if (i == 0) begin
          ln.push_back(c0[15:0]);
          push(c0);
        end else begin
          ln.push_back({8'h0, c0[7:0]});
          ln.push_back({8'h0, c1[7:0]});
          push(i == 1 ? {c1[7:0], c0[7:0]} : {c0[7:0], c1[7:0]});
        end
      end
      src_u.send_line(ln, 16'h0, i[0]);
      repeat (3) @(posedge pclk);
    end
    // external write enable drops the words where it is low
    wr(`OFS_GAIN_FACTOR, 32'h200);
    wr(`OFS_OUTPUT_CLIP_LIMIT, 32'hFFF);
    wr(`OFS_INPUT_CONFIG_TWO, 32'h10);
    ln = {16'h0123, 16'h0456, 16'h0789, 16'h0ABC};
    push(32'h0123);
    push(32'h0789);
    src_u.send_line(ln, 16'h0005, 1'b0);
    repeat (3) @(posedge pclk);
    // resize window holds back the first two words; realign then opens it with no line start
    wr(`OFS_INPUT_CONFIG_TWO, 32'h0);
    wr(`OFS_RESIZE_START_POSITION, 32'h2);
    ln = {16'h0011, 16'h0022, 16'h0033, 16'h0044};
    push(32'h0033);
    push(32'h0044);
    src_u.send_line(ln, 16'h0, 1'b0);
    repeat (3) @(posedge pclk);
    wr(`OFS_RESIZE_START_POSITION, 32'h8);
    wr(`OFS_RESIZE_START_POSITION, 32'h2008);
    ln = {16'h0055, 16'h0066};
    push(32'h0055);
    push(32'h0066);
    src_u.send_line(ln, 16'h0, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    wr(`OFS_RESIZE_START_POSITION, 32'h0);
    // every combination of the two sync polarities
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_INPUT_CONFIG_TWO, i << 1);
      repeat (3) @(posedge pclk);
      check({pix_out.hsync, pix_out.vsync}, {pix_in.hsync ^ i[0], pix_in.vsync ^ i[1]});
    end
    // frame-start interrupt from each source; the other source must stay silent
    wr(`OFS_INPUT_CONFIG_TWO, 32'h0);
    wr(`OFS_IRQ_STATUS, 32'h3);
    wr(`OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_INPUT_CONFIG_TWO, i);
      src_u.vpulse(~i[0]);
      repeat (4) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      src_u.vpulse(i[0]);
      repeat (4) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
      check(rd & 32'h1, 32'h1);
      wr(`OFS_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge pclk);
      check({31'h0, irq}, 32'h0); // writing one clears the event
    end
    wr(`OFS_IRQ_MASK, 32'h0);
    src_u.vpulse(1'b1);
    repeat (4) @(posedge pclk);
    check({31'h0, irq}, 32'h0); // masked event keeps the line low
    repeat (5) @(posedge pclk);
    check(expq.size(), 32'h0); // every expected word came out
    give_verdict();
  end
endmodule : pipe_input_format_config_tb_top
